// *** inc/srr_pkg.sv ***
// ==========================================================
// constants for the secondary receive slot router
package srr_pkg;
	// register port geometry
	localparam int ADDR_W = 8;
	localparam int REG_W = 8;
	localparam int CFG_W = 7;
	localparam int NUM_CH = 2;

	// route register addresses and reset values, channel 6 first
	localparam logic [ADDR_W-1:0] ROUTE_ADDR [NUM_CH] = '{8'h2D, 8'h2E};
	localparam logic [REG_W-1:0] ROUTE_RESET [NUM_CH] = '{8'h05, 8'h06};

	// field positions inside a route register
	localparam int RSVD_BIT = 7;
	localparam int SRC_HI = 6;
	localparam int SRC_LO = 5;
	localparam int SLOT_HI = 4;
	localparam int SLOT_LO = 0;
	localparam int SLOT_FIELD_W = 5;
	localparam int HALF_BIT = 4;

	// source selector codes
	localparam int SRC_W = 2;
	localparam logic [SRC_W-1:0] SRC_OFF = 2'h0;
	localparam logic [SRC_W-1:0] SRC_PLAY = 2'h1;
	localparam logic [SRC_W-1:0] SRC_LOOP = 2'h2;
	localparam logic [SRC_W-1:0] SRC_PEER = 2'h3;

	// chained peer numbers per channel
	localparam int PEER_W = 2;
	localparam logic [PEER_W-1:0] PEER_NONE = 2'h0;
	localparam logic [PEER_W-1:0] PEER_ID [NUM_CH] = '{2'h1, 2'h2};

	// frame layout codes on fmt_i
	localparam int FMT_W = 2;
	localparam logic [FMT_W-1:0] FMT_TDM = 2'h0;
	localparam logic [FMT_W-1:0] FMT_I2S = 2'h1;
	localparam logic [FMT_W-1:0] FMT_LJ = 2'h2;

	// channel tag width on the output stream
	localparam int CHAN_W = 1;
endpackage

// *** core/srr_fifo.sv ***
`timescale 1ns/1ps
// ==========================================================
// first-word-registered fifo
module srr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// clock and reset
	input  wire logic             clock_i,
	input  wire logic             nrst_i,
	// fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [PTR_W:0] FULL_CNT = (PTR_W+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [PTR_W:0]   count;

	// handshake terms; output stage adds one word beyond DEPTH
	wire push = in_valid_i & in_ready_o;
	wire load = (~out_valid_o | out_ready_i) & (count != '0);
	wire [PTR_W:0] next_count = count + (PTR_W+1)'(push)
		- (PTR_W+1)'(load);

	assign in_ready_o = (count != FULL_CNT);

	// storage writes carry no reset
	always_ff @(posedge clock_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	// pointers, fill level and output register
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			out_valid_o <= 1'b0;
			out_data_o <= '0;
		end else begin
			count <= next_count;
			if (push) begin
				wr_ptr <= wr_ptr + PTR_W'(1);
			end
			if (load) begin
				out_data_o <= mem[rd_ptr];
				rd_ptr <= rd_ptr + PTR_W'(1);
				out_valid_o <= 1'b1;
			end else if (out_ready_i) begin
				out_valid_o <= 1'b0;
			end
		end
	end
endmodule

// *** core/srr_top.sv ***
`timescale 1ns/1ps
module srr_top #(
	parameter int WORD_W = 32,
	parameter int FIFO_DEPTH = 32
) (
	// system clock and reset
	input  wire logic                        clock_i,
	input  wire logic                        nrst_i,
	// register port
	input  wire logic [srr_pkg::ADDR_W-1:0]  reg_addr_i,
	input  wire logic                        reg_wr_i,
	input  wire logic                        reg_rd_i,
	input  wire logic [srr_pkg::REG_W-1:0]   reg_wdata_i,
	output logic      [srr_pkg::REG_W-1:0]   reg_rdata_o,
	// frame layout select
	input  wire logic [srr_pkg::FMT_W-1:0]   fmt_i,
	// secondary audio port link
	input  wire logic                        bclk_i,
	input  wire logic                        fsync_i,
	input  wire logic                        sdata_i,
	// adc loopback words
	input  wire logic [WORD_W-1:0]           adc2_word_i,
	input  wire logic [WORD_W-1:0]           adc3_word_i,
	// routed word stream
	output logic                             out_valid_o,
	input  wire logic                        out_ready_i,
	output logic      [WORD_W-1:0]           out_data_o,
	output logic      [srr_pkg::CHAN_W-1:0]  out_chan_o,
	output logic      [srr_pkg::SRC_W-1:0]   out_dest_o,
	output logic      [srr_pkg::PEER_W-1:0]  out_peer_o,
	output logic                             drop_o
);
	import srr_pkg::*;

	localparam int BIT_W = $clog2(WORD_W);
	localparam int CNT_W = SLOT_FIELD_W + BIT_W;
	localparam int SYNC_W = FMT_W + NUM_CH * CFG_W;
	localparam int ENT_W = WORD_W + CHAN_W + SRC_W + PEER_W;
	localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(WORD_W - 1);
	localparam logic [CNT_W:0] CNT_IDLE = {1'b1, {CNT_W{1'b0}}};

	// ======================================================
	// register file, system domain
	logic [NUM_CH-1:0][CFG_W-1:0] route_cfg;
	logic [NUM_CH-1:0]            reg_hit;
	logic [REG_W-1:0]             rd_word;

	// address decode per channel
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : dec_g
			assign reg_hit[g] = (reg_addr_i == ROUTE_ADDR[g]);
		end
	endgenerate

	// reserved top bit
	// read mux; reserved bit and unmapped addresses read zero
	always_comb begin
		rd_word = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			if (reg_hit[i]) begin
				rd_word = {{(REG_W - CFG_W){1'b0}}, route_cfg[i]};
			end
		end
	end

	// reset values for both channels
	// writes drop bit 7, so it stays read-only
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < NUM_CH; i++) begin
				route_cfg[i] <= ROUTE_RESET[i][CFG_W-1:0];
			end
		end else if (reg_wr_i) begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (reg_hit[i]) begin
					route_cfg[i] <= reg_wdata_i[CFG_W-1:0];
				end
			end
		end
	end

	// read data registered one cycle after the strobe
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			reg_rdata_o <= '0;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rd_word;
		end
	end

	// ======================================================
	// crossings into the bit clock domain
	logic                         lrst_s1;
	logic                         lrst_n;
	logic [SYNC_W-1:0]            cs1;
	logic [SYNC_W-1:0]            cs2;
	logic [SYNC_W-1:0]            cs3;
	logic [FMT_W-1:0]             fmt_l;
	logic [NUM_CH-1:0][CFG_W-1:0] route_l;
	wire  [SYNC_W-1:0]            cfg_bus = {fmt_i, route_cfg};

	// reset only acts while the bit clock runs
	always_ff @(posedge bclk_i) begin
		lrst_s1 <= nrst_i;
		lrst_n <= lrst_s1;
	end

	// settings bundle, taken only after two equal samples
	always_ff @(posedge bclk_i) begin
		cs1 <= cfg_bus;
		cs2 <= cs1;
		cs3 <= cs2;
	end

	// avoids adopting a torn mix of old and new bits
	always_ff @(posedge bclk_i) begin
		if (!lrst_n) begin
			fmt_l <= FMT_TDM;
			for (int i = 0; i < NUM_CH; i++) begin
				route_l[i] <= ROUTE_RESET[i][CFG_W-1:0];
			end
		end else if (cs2 == cs3) begin
			{fmt_l, route_l} <= cs3;
		end
	end

	// ======================================================
	// frame tracking, bit clock domain
	logic             fs_r;
	logic             fs_d1;
	logic             fs_d2;
	logic             sd_r;
	logic             half_q;
	logic [CNT_W:0]   cnt;

	wire is_lj = (fmt_l == FMT_LJ);
	wire is_tdm = (fmt_l == FMT_TDM);

	// lj puts bit 0 on the sync edge, others one clock later
	wire fs_edge = is_lj ? (fs_r ^ fs_d1) : (fs_d1 ^ fs_d2);
	wire fs_lvl = is_lj ? fs_r : fs_d1;
	wire start = is_tdm ? (fs_edge & fs_lvl) : fs_edge;
	wire half_right = is_lj ? ~fs_lvl : fs_lvl;

	// position of the bit being sampled now
	wire [CNT_W:0] cnt_cur = start ? '0 : cnt;
	wire half_cur = start ? half_right : half_q;
	// a half ends after slot 15, so a layout change never resumes mid-slot
	wire pos_ok = ~cnt_cur[CNT_W] & (is_tdm | ~cnt_cur[CNT_W-1]);
	wire [SLOT_FIELD_W-1:0] slot_cur = cnt_cur[CNT_W-1:BIT_W];
	wire [BIT_W-1:0] bit_cur = cnt_cur[BIT_W-1:0];

	// link pins sampled on the rising bit clock edge
	always_ff @(posedge bclk_i) begin
		if (!lrst_n) begin
			fs_r <= 1'b0;
			fs_d1 <= 1'b0;
			fs_d2 <= 1'b0;
			sd_r <= 1'b0;
		end else begin
			fs_r <= fsync_i;
			fs_d1 <= fs_r;
			fs_d2 <= fs_d1;
			sd_r <= sdata_i;
		end
	end

	// bit counter parks once out of range until the next sync
	always_ff @(posedge bclk_i) begin
		if (!lrst_n) begin
			cnt <= CNT_IDLE;
			half_q <= 1'b0;
		end else begin
			half_q <= half_cur;
			if (pos_ok) begin
				cnt <= cnt_cur + (CNT_W+1)'(1);
			end else begin
				cnt <= CNT_IDLE;
			end
		end
	end

	// ======================================================
	// per-channel capture and hand-over to system domain
	wire  [NUM_CH-1:0][WORD_W-1:0] adc_word = {adc3_word_i, adc2_word_i};
	logic [NUM_CH-1:0][ENT_W-1:0]  entry;
	logic [NUM_CH-1:0]             pend;
	logic [NUM_CH-1:0]             grant;
	logic [NUM_CH-1:0]             ovr;
	wire                           fifo_in_ready;

	generate
		for (g = 0; g < NUM_CH; g++) begin : ch_g
			localparam logic [NUM_CH-1:0] LOW = NUM_CH'((1 << g) - 1);
			logic [WORD_W-1:0] sh;
			logic [WORD_W-1:0] hold;
			logic              tgl;
			logic              ts1;
			logic              ts2;
			logic              ts3;
			logic [WORD_W-1:0] word_s;
			logic [SRC_W-1:0]  dest_s;

			wire [SRC_W-1:0] src_l = route_l[g][SRC_HI:SRC_LO];
			wire [SLOT_FIELD_W-1:0] idx = route_l[g][SLOT_HI:SLOT_LO];
			wire [SRC_W-1:0] src_s = route_cfg[g][SRC_HI:SRC_LO];

			wire slot_ok = is_tdm ? (slot_cur == idx)
				: (~slot_cur[HALF_BIT]
				& (slot_cur[HALF_BIT-1:0] == idx[HALF_BIT-1:0])
				& (half_cur == idx[HALF_BIT]));
			wire hit = pos_ok & (src_l != SRC_OFF) & slot_ok;
			wire last = hit & (bit_cur == LAST_BIT);
			wire evt = ts2 ^ ts3;
			wire take = evt & (src_s != SRC_OFF);

			// shift msb first, hand over on last bit
			always_ff @(posedge bclk_i) begin
				if (!lrst_n) begin
					sh <= '0;
					hold <= '0;
					tgl <= 1'b0;
				end else if (hit) begin
					sh <= {sh[WORD_W-2:0], sd_r};
					if (last) begin
						hold <= {sh[WORD_W-2:0], sd_r};
						tgl <= ~tgl;
					end
				end
			end

			// hold stays put for a whole slot after the toggle
			always_ff @(posedge clock_i) begin
				if (!nrst_i) begin
					ts1 <= 1'b0;
					ts2 <= 1'b0;
					ts3 <= 1'b0;
				end else begin
					ts1 <= tgl;
					ts2 <= ts1;
					ts3 <= ts2;
				end
			end

			always_ff @(posedge clock_i) begin
				if (!nrst_i) begin
					word_s <= '0;
					dest_s <= SRC_OFF;
				end else if (take) begin
					word_s <= (src_s == SRC_LOOP) ? adc_word[g] : hold;
					dest_s <= src_s;
				end
			end

			// a new word wins over a clear in the same cycle
			always_ff @(posedge clock_i) begin
				if (!nrst_i) begin
					pend[g] <= 1'b0;
				end else if (take) begin
					pend[g] <= 1'b1;
				end else if (grant[g]) begin
					pend[g] <= 1'b0;
				end
			end

			// lowest channel first; stall holds the word
			assign grant[g] = pend[g] & fifo_in_ready & ~|(pend & LOW);
			assign ovr[g] = take & pend[g] & ~grant[g];
			assign entry[g] = {word_s, CHAN_W'(g), dest_s,
				(dest_s == SRC_PEER) ? PEER_ID[g] : PEER_NONE};
		end
	endgenerate

	// ======================================================
	// delivery queue
	logic [ENT_W-1:0] push_data;
	logic [ENT_W-1:0] pop_data;
	wire              push_valid = |pend;

	// pick the lowest pending channel
	always_comb begin
		push_data = '0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (pend[i]) begin
				push_data = entry[i];
			end
		end
	end

	srr_fifo #(
		.WIDTH (ENT_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock_i     (clock_i),
		.nrst_i      (nrst_i),
		.in_valid_i  (push_valid),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (push_data),
		.out_valid_o (out_valid_o),
		.out_ready_i (out_ready_i),
		.out_data_o  (pop_data)
	);

	// fields of the registered queue head
	assign {out_data_o, out_chan_o, out_dest_o, out_peer_o} = pop_data;

	// a pending word overwritten before it got queued
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			drop_o <= 1'b0;
		end else begin
			drop_o <= |ovr;
		end
	end
endmodule

// *** dv/srr_chk.sv ***
`timescale 1ns/1ps
// ==========================================================
// port checker for the slot router
module srr_chk
	import srr_pkg::*;
#(
	parameter int WORD_W = 32
) (
	// clock, reset and register port
	input wire logic              clock_i, nrst_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic              reg_wr_i, reg_rd_i,
	input wire logic [REG_W-1:0]  reg_wdata_i, reg_rdata_o,
	// layout, link and loopback
	input wire logic [FMT_W-1:0]  fmt_i,
	input wire logic              bclk_i, fsync_i, sdata_i,
	input wire logic [WORD_W-1:0] adc2_word_i, adc3_word_i,
	// routed stream
	input wire logic              out_valid_o, out_ready_i,
	input wire logic [WORD_W-1:0] out_data_o,
	input wire logic [CHAN_W-1:0] out_chan_o,
	input wire logic [SRC_W-1:0]  out_dest_o,
	input wire logic [PEER_W-1:0] out_peer_o,
	input wire logic              drop_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	// address hits one of the two route registers
	wire mapped = reg_addr_i == ROUTE_ADDR[0] || reg_addr_i == ROUTE_ADDR[1];

	// ==========================================================
	// stream
	a_drop_pulse: assert property (drop_o |=> !drop_o)
		else $error("drop pulse too long");
	a_word_held: assert property (out_valid_o && !out_ready_i
		|=> out_valid_o && $stable(out_data_o)) else $error("word lost");
	a_tag_held: assert property (out_valid_o && !out_ready_i
		|=> $stable({out_chan_o, out_dest_o, out_peer_o}))
		else $error("tag changed while stalled");
	a_dest_enabled: assert property (out_valid_o
		|-> out_dest_o != SRC_OFF) else $error("disabled channel delivered");
	a_peer_match: assert property (out_valid_o &&
		out_dest_o == SRC_PEER |-> out_peer_o == PEER_ID[out_chan_o])
		else $error("wrong peer number");
	a_peer_clear: assert property (out_valid_o &&
		out_dest_o != SRC_PEER |-> out_peer_o == PEER_NONE)
		else $error("peer number without peer route");

	// ==========================================================
	// register port
	a_rsvd_zero: assert property (reg_rd_i |=> !reg_rdata_o[RSVD_BIT])
		else $error("reserved bit read as one");
	a_unmapped_zero: assert property (reg_rd_i && !mapped
		|=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
	a_rdata_held: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved without a read");

	// main scenarios reached
	c_drop: cover property (drop_o);
	c_loop: cover property (out_valid_o && out_dest_o == SRC_LOOP);
	c_peer: cover property (out_valid_o && out_dest_o == SRC_PEER);
endmodule

bind srr_top srr_chk #(.WORD_W(WORD_W)) u_srr_chk (.clock_i(clock_i),
	.nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
	.reg_rdata_o(reg_rdata_o), .fmt_i(fmt_i), .bclk_i(bclk_i),
	.fsync_i(fsync_i), .sdata_i(sdata_i), .adc2_word_i(adc2_word_i),
	.adc3_word_i(adc3_word_i), .out_valid_o(out_valid_o),
	.out_ready_i(out_ready_i), .out_data_o(out_data_o),
	.out_chan_o(out_chan_o), .out_dest_o(out_dest_o),
	.out_peer_o(out_peer_o), .drop_o(drop_o));

// *** dv/srr_host.sv ***
`timescale 1ns/1ps
// ==========================================================
// host on the secondary port: bit clock runs only in calls
module srr_host #(
	parameter int WORD_W = 8
) (
	// link outputs
	output logic bclk_o = 1'b0,
	output logic fsync_o = 1'b0,
	output logic sdata_o = 1'b0
);
	// free clocks with toggling data, used during reset
	task automatic run(input int n);
		repeat (n) begin
			sdata_o = ~sdata_o;
			#15 bclk_o = 1'b1;
			#15 bclk_o = 1'b0;
		end
	endtask

	// one frame of 32 slots; prelude of 6 bits settles the idle level,
	// too short to complete any slot
	task automatic frame(input logic [1:0] fmt, input logic [WORD_W-1:0] w [32]);
		int n, k;
		n = 32 * WORD_W;
		// one trailing edge lets the last sampled bit be shifted in
		for (int c = -6; c <= n + 1; c++) begin
			// frame sync per layout, left half first
			case (fmt)
				2'h0: fsync_o = c == 0;
				2'h2: fsync_o = c >= 0 && c < n / 2;
				default: fsync_o = c < 0 || c >= n / 2;
			endcase
			k = fmt == 2'h2 ? c : c - 1;
			// released line toggles instead of holding
			sdata_o = k >= 0 && k < n ? w[k / WORD_W][WORD_W - 1 - k % WORD_W]
				: ~sdata_o;
			#15 bclk_o = 1'b1;
			#15 bclk_o = 1'b0;
		end
	endtask
endmodule

// *** dv/srr_top_tb.sv ***
`timescale 1ns/1ps
// ==========================================================
// bench for the slot router
module srr_top_tb;
	import srr_pkg::*;
	localparam int W = 8;
	logic clock_i = 0, nrst_i = 0, wr = 0, rd = 0, rdy = 0, stall = 0;
	logic bclk, fs, sd, ov, ch, drop;
	logic [7:0] addr = 0, wd = 0, rdat;
	logic [1:0] fmt = 0, dest, peer, c6, c7;
	logic [4:0] s6, s7;
	logic [W-1:0] a2 = 0, a3 = 0, odat;
	logic [W-1:0] w [32];
	logic [W+4:0] exq[$], got[$];
	int n_mismatch = 0, tests_run = 0, seed = 32'he8e7, cyc = 0, ndrop = 0;

	srr_top #(.WORD_W(W)) u_srr_top (.clock_i(clock_i), .nrst_i(nrst_i),
		.reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wd),
		.reg_rdata_o(rdat), .fmt_i(fmt), .bclk_i(bclk), .fsync_i(fs),
		.sdata_i(sd), .adc2_word_i(a2), .adc3_word_i(a3),
		.out_valid_o(ov), .out_ready_i(rdy), .out_data_o(odat),
		.out_chan_o(ch), .out_dest_o(dest), .out_peer_o(peer),
		.drop_o(drop));
	srr_host #(.WORD_W(W)) u_srr_host (.bclk_o(bclk), .fsync_o(fs),
		.sdata_o(sd));

	// system clock, 40 ns
	initial begin
		forever #20 clock_i = ~clock_i;
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic conclude();
		$display("mismatches %0d checks %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		addr = a; wd = d; wr = 1;
		@(posedge clock_i) #1 wr = 0;
		// idle edge so a following write never re-raises wr at once
		@(posedge clock_i) #1;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		addr = a; rd = 1;
		@(posedge clock_i) #1 rd = 0;
		@(posedge clock_i) #1 chk(rdat, e);
	endtask

	// expected record: chan, dest, peer, word
	function automatic logic [W+4:0] ex(bit c, logic [1:0] k, logic [4:0] s);
		return {c, k, k == SRC_PEER ? PEER_ID[c] : PEER_NONE,
			k == SRC_LOOP ? (c ? a3 : a2) : w[s]};
	endfunction

	// stream monitor, random sink readiness, hang guard
	always @(posedge clock_i) begin
		if (ov && rdy) got.push_back({ch, dest, peer, odat});
		if (drop) ndrop++;
		cyc++;
		#1 rdy = !stall && ($random(seed) & 1);
		if (cyc == 20000) begin
			n_mismatch++;
			conclude();
		end
	end

	// fill the frame words and adc words at random
	task automatic rand_words();
		for (int j = 0; j < 32; j++) w[j] = W'($random(seed));
		a2 = W'($random(seed));
		a3 = W'($random(seed));
	endtask

	initial begin
		fork
			u_srr_host.run(12);
		join_none
		repeat (6) @(posedge clock_i);
		#1 nrst_i = 1;
		rdc(8'h2D, 8'h05);
		rdc(8'h2E, 8'h06);
		rdc(8'h2C, 8'h00);
		wreg(8'h2D, 8'hFF);
		rdc(8'h2D, 8'h7F);
		// corners first: every code, slot edges, shared slot, all layouts
		for (int i = 0; i < 24; i++) begin
			c6 = i < 4 ? 2'(i) : 2'($random(seed));
			c7 = i < 4 ? 2'(3 - i) : 2'($random(seed));
			s6 = i == 0 ? 5'h00 : i == 1 ? 5'h0F : i == 2 ? 5'h07 : 5'($random(seed));
			s7 = i == 0 ? 5'h1F : i == 1 ? 5'h10 : i == 2 ? 5'h07 : 5'($random(seed));
			wreg(8'h2D, {1'b0, c6, s6});
			wreg(8'h2E, {1'b0, c7, s7});
			rdc(8'h2E, {1'b0, c7, s7});
			fmt = 2'(i % 3);
			rand_words();
			if (c6 != SRC_OFF && (s6 <= s7 || c7 == SRC_OFF)) exq.push_back(ex(0, c6, s6));
			if (c7 != SRC_OFF) exq.push_back(ex(1, c7, s7));
			if (c6 != SRC_OFF && s6 > s7 && c7 != SRC_OFF) exq.push_back(ex(0, c6, s6));
			u_srr_host.frame(fmt, w);
			// settle: the last word needs a few bit and system clocks
			repeat (12) @(posedge clock_i);
			#1;
			for (int k = 0; k < 300 && got.size() < exq.size(); k++)
				@(posedge clock_i) #1;
			chk(got.size(), exq.size());
			while (exq.size() > 0 && got.size() > 0)
				chk(got.pop_front(), exq.pop_front());
			exq.delete();
			got.delete();
		end
		// stalled sink: fill the buffer until words are dropped, then drain
		stall = 1;
		ndrop = 0;
		wreg(8'h2D, 8'h21);
		wreg(8'h2E, 8'h22);
		fmt = 2'h0;
		repeat (18) begin
			rand_words();
			u_srr_host.frame(fmt, w);
		end
		stall = 0;
		@(posedge clock_i) #1;
		for (int k = 0; k < 400 && got.size() + ndrop < 36; k++)
			@(posedge clock_i) #1;
		chk(got.size() + ndrop, 36);
		chk(ndrop > 0, 1);
		conclude();
	end
endmodule
